// ---- rtl/dfs_pkg.sv ----
// Package of the disk format and transfer sequencer.
// Assumes a 32-bit APB register bus and a single 10 MHz clock.
package dfs_pkg;
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFF_DRIVE_CMD = 8'h00;
    localparam logic [7:0] OFF_OP_CMD = 8'h04;
    localparam logic [7:0] OFF_DISK_FMT = 8'h08;
    localparam logic [7:0] OFF_SECTOR_CNT = 8'h0c;
    localparam logic [7:0] OFF_SECTOR_OPS = 8'h10;
    localparam logic [7:0] OFF_HDR_COUNT = 8'h14;
    localparam logic [7:0] OFF_HDR_PAT_LO = 8'h18;
    localparam logic [7:0] OFF_HDR_PAT_HI = 8'h1c;
    localparam logic [7:0] OFF_HDR_SUBST = 8'h20;
    localparam logic [7:0] OFF_INTERLOCK = 8'h24;
    localparam logic [7:0] OFF_DMA_ADDR = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    localparam logic [7:0] OFF_ERROR = 8'h30;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int OC_GLOBAL_IRQ = 0;
    localparam int OC_HDR_IRQ = 1;
    localparam int OC_INTERLOCK = 2;
    localparam int DF_TABLE = 0;
    localparam int DF_HARD_SOFT = 1;
    localparam int DF_MFM = 2;
    localparam int DF_ID_CHECK = 3;
    localparam int DF_DATA_CHECK = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_HDR_CPL = 2;
    localparam int ST_ERROR = 3;
    localparam int ER_LATE = 0;
    localparam int ER_OPCODE = 1;
    localparam int ER_DISK = 2;
    localparam int ER_NOT_FOUND = 3;

    localparam int HDR_BYTES = 6;
    localparam logic [2:0] HDR_CNT_MIN = 3'd2;
    localparam logic [2:0] HDR_CNT_RST = 3'd4;

    // --------------------------------------------------------------
    // Drive command opcodes
    // --------------------------------------------------------------
    localparam logic [7:0] read_one_sector_cmd = 8'hd2;
    localparam logic [7:0] read_sector_header_cmd = 8'h72;
    localparam logic [7:0] read_many_logical_cmd = 8'hd6;
    localparam logic [7:0] read_whole_track_cmd = 8'hd4;
    localparam logic [7:0] read_track_blind_cmd = 8'hc4;
    localparam logic [7:0] read_headers_many_cmd = 8'h74;
    localparam logic [7:0] read_track_data_header_cmd = 8'hf4;
    localparam logic [7:0] write_one_sector_cmd = 8'h92;
    localparam logic [7:0] write_many_logical_cmd = 8'h96;
    localparam logic [7:0] write_whole_track_cmd = 8'h84;
    localparam logic [7:0] format_track_cmd = 8'hac;
    localparam logic [7:0] format_track_nogap_cmd = 8'ha4;
    localparam logic [7:0] find_header_cmd = 8'h52;
    // Bit pattern 01010110 taken as the code
    localparam logic [7:0] find_headers_many_cmd = 8'h56;
    localparam logic [7:0] recover_header_cmd = 8'h62;
    localparam logic [7:0] controller_reenable_cmd = 8'h01;
    localparam logic [7:0] no_operation_cmd = 8'h00;

    typedef enum logic [2:0] {
        CL_NONE = 3'b000,
        CL_FORMAT = 3'b001,
        CL_TRACK = 3'b010,
        CL_MULTI = 3'b011,
        CL_SINGLE = 3'b100,
        CL_REENABLE = 3'b101,
        CL_BAD = 3'b110
    } dfs_class_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAIT_IDX = 3'b001,
        S_HDR = 3'b010,
        S_FETCH = 3'b011,
        S_DATA = 3'b100,
        S_SEARCH = 3'b101,
        S_DONE = 3'b110
    } dfs_state_e;
endpackage : dfs_pkg

// ---- rtl/dfs_hdr_if.sv ----
// Interface between the sequencer and its header byte source.
// Assumes both ends on the sequencer clock.
`timescale 1ns/1ps
interface dfs_hdr_if;
    logic load;
    logic [2:0] idx;
    logic table_mode;
    logic [7:0] dma_byte;
    logic [7:0] sector_cnt;
    logic [47:0] pattern;
    logic [5:0] subst;
    logic [7:0] byte_out;
    logic strobe;

    modport ctl (
        output load, idx, table_mode, dma_byte, sector_cnt, pattern, subst,
        input byte_out, strobe
    );
    modport src (
        input load, idx, table_mode, dma_byte, sector_cnt, pattern, subst,
        output byte_out, strobe
    );
endinterface : dfs_hdr_if

// ---- rtl/dfs_sync.sv ----
// Two-stage synchroniser for pin inputs.
// Assumes inputs asynchronous to clk_sys_i.
`timescale 1ns/1ps
module dfs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : dfs_sync

// ---- rtl/dfs_hdr_src.sv ----
// Header byte source: picks table byte, sector counter or pattern.
// Assumes load pulses come from the sequencer on the same clock.
`timescale 1ns/1ps
module dfs_hdr_src (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    dfs_hdr_if.src hif
);
    import dfs_pkg::*;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hif.byte_out <= 8'h00;
            hif.strobe <= 1'b0;
        end else begin
            hif.strobe <= hif.load;
            if (hif.load) begin
                if (hif.table_mode) begin
                    hif.byte_out <= hif.dma_byte;
                end else if (hif.subst[hif.idx]) begin
                    hif.byte_out <= hif.sector_cnt;
                end else begin
                    hif.byte_out <= hif.pattern[hif.idx*8 +: 8];
                end
            end
        end
    end
endmodule : dfs_hdr_src

// ---- rtl/dfs_top.sv ----
// Disk format and transfer sequencer with an APB register slave.
// Assumes disk-side strobes on clk_sys_i; index pulse is a raw pin.
//
// Contract
// - Interrupt at format end, outcome in status
// - Table mode takes header bytes from memory
// - Format runs index to next index; the code also ends it once the operations count is used up
// - Table flag selects header source
// - Interlock: header complete interrupt per sector
// - Missing confirm: late error on next command
// - Substitute flag picks counter over pattern
// - Decode the read opcodes
// - Decode the write and format opcodes
// - Decode find, recover, re-enable, no-op
// - Single sector: match header, request bus
// - Interrupt at single-sector command end
// - Pattern and count registers reused per sector
// - Counter copied into header, then incremented
// - Per sector: count down, sector up
`timescale 1ns/1ps
module dfs_top (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic index_i,
    input wire logic hdr_match_i,
    input wire logic sector_done_i,
    input wire logic disk_error_i,
    output logic [7:0] hdr_byte_o,
    output logic hdr_strobe_o,
    output logic fmt_active_o,
    output logic bus_req_o,
    output logic dma_req_o,
    output logic [15:0] dma_addr_o,
    input wire logic [7:0] dma_data_i,
    input wire logic dma_ack_i,
    output logic irq_o
);
    import dfs_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [2:0] op_cmd;
    logic [4:0] disk_fmt;
    logic [7:0] sector_number_counter;
    logic [7:0] sector_operations_count;
    logic [2:0] hdr_count;
    logic [47:0] hdr_pat;
    logic [5:0] sector_counter_substitute;
    logic [3:0] status;
    logic [3:0] error;
    logic [7:0] cur_cmd;
    dfs_class_e cur_class;
    dfs_state_e state;
    logic [2:0] byte_idx;
    logic confirmed;
    logic late_pend;
    logic seen_idx;
    logic idx_sync;
    logic idx_prev;
    logic idx_rise;
    logic wr_en;
    logic cmd_wr;
    logic confirm_wr;
    logic addr_ok;
    logic last_byte;
    logic in_table;
    logic start_cmd;
    logic sector_end;
    logic [31:0] rd_mux;
    dfs_class_e wr_class;

    dfs_hdr_if hif ();

    dfs_sync #(
        .W(1)
    ) u_idx_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(index_i),
        .sync_o(idx_sync)
    );

    dfs_hdr_src u_hdr_src (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .hif(hif)
    );

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    function automatic dfs_class_e classify(input logic [7:0] op);
        case (op)
            format_track_cmd, format_track_nogap_cmd: classify = CL_FORMAT;
            read_whole_track_cmd, read_track_blind_cmd,
            read_track_data_header_cmd, write_whole_track_cmd:
                classify = CL_TRACK;
            read_many_logical_cmd, read_headers_many_cmd,
            write_many_logical_cmd, find_headers_many_cmd:
                classify = CL_MULTI;
            read_one_sector_cmd, read_sector_header_cmd,
            write_one_sector_cmd, find_header_cmd, recover_header_cmd:
                classify = CL_SINGLE;
            controller_reenable_cmd: classify = CL_REENABLE;
            no_operation_cmd: classify = CL_NONE;
            default: classify = CL_BAD;
        endcase
    endfunction : classify

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_comb begin
        wr_en = psel_i && penable_i && pwrite_i;
        cmd_wr = wr_en && (paddr_i == OFF_DRIVE_CMD);
        confirm_wr = wr_en && (paddr_i == OFF_INTERLOCK);
        wr_class = classify(pwdata_i[7:0]);
        // Late confirm blocks the command: its parameters are stale
        start_cmd = cmd_wr && (state == S_IDLE) && !late_pend;
        idx_rise = idx_sync && !idx_prev;
        in_table = disk_fmt[DF_TABLE] && (cur_class == CL_FORMAT);
        last_byte = (byte_idx == hdr_count - 3'd1);
        sector_end = (state == S_DATA) && sector_done_i;
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            OFF_DRIVE_CMD: rd_mux = {24'h00_0000, cur_cmd};
            OFF_OP_CMD: rd_mux = {29'h0000_0000, op_cmd};
            OFF_DISK_FMT: rd_mux = {27'h000_0000, disk_fmt};
            OFF_SECTOR_CNT: rd_mux = {24'h00_0000, sector_number_counter};
            OFF_SECTOR_OPS: rd_mux = {24'h00_0000, sector_operations_count};
            OFF_HDR_COUNT: rd_mux = {29'h0000_0000, hdr_count};
            OFF_HDR_PAT_LO: rd_mux = hdr_pat[31:0];
            OFF_HDR_PAT_HI: rd_mux = {16'h0000, hdr_pat[47:32]};
            OFF_HDR_SUBST: rd_mux = {26'h000_0000, sector_counter_substitute};
            OFF_INTERLOCK: rd_mux = {31'h0000_0000, confirmed};
            OFF_DMA_ADDR: rd_mux = {16'h0000, dma_addr_o};
            OFF_STATUS: rd_mux = {28'h000_0000, status};
            OFF_ERROR: rd_mux = {28'h000_0000, error};
            default: addr_ok = 1'b0;
        endcase
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    // Setup registers: writable at any time, also while a command runs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            op_cmd <= 3'h0;
            disk_fmt <= 5'h00;
            hdr_count <= HDR_CNT_RST;
            hdr_pat <= 48'h0000_0000_0000;
            sector_counter_substitute <= 6'h00;
        end else if (wr_en) begin
            case (paddr_i)
                OFF_OP_CMD: op_cmd <= pwdata_i[2:0];
                OFF_DISK_FMT: disk_fmt <= pwdata_i[4:0];
                OFF_HDR_COUNT: begin
                    // Clamped so the byte index never leaves the pattern
                    if (pwdata_i[2:0] < HDR_CNT_MIN) begin
                        hdr_count <= HDR_CNT_MIN;
                    end else if (pwdata_i[2:0] > 3'(HDR_BYTES)) begin
                        hdr_count <= 3'(HDR_BYTES);
                    end else begin
                        hdr_count <= pwdata_i[2:0];
                    end
                end
                OFF_HDR_PAT_LO: hdr_pat[31:0] <= pwdata_i;
                OFF_HDR_PAT_HI: hdr_pat[47:32] <= pwdata_i[15:0];
                OFF_HDR_SUBST: sector_counter_substitute <= pwdata_i[5:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            idx_prev <= 1'b0;
        end else begin
            idx_prev <= idx_sync;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= S_IDLE;
            cur_cmd <= 8'h00;
            cur_class <= CL_NONE;
            byte_idx <= 3'd0;
            seen_idx <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start_cmd) begin
                        cur_cmd <= pwdata_i[7:0];
                        cur_class <= wr_class;
                        seen_idx <= 1'b0;
                        case (wr_class)
                            CL_FORMAT, CL_TRACK: state <= S_WAIT_IDX;
                            CL_MULTI, CL_SINGLE: state <= S_SEARCH;
                            CL_BAD: state <= S_DONE;
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_WAIT_IDX: begin
                    if (disk_error_i) begin
                        state <= S_DONE;
                    end else if (idx_rise) begin
                        byte_idx <= 3'd0;
                        state <= (cur_class == CL_FORMAT) ? S_HDR : S_DATA;
                    end
                end
                S_HDR: begin
                    if (idx_rise || disk_error_i) begin
                        state <= S_DONE;
                    end else if (in_table) begin
                        state <= S_FETCH;
                    end else if (last_byte) begin
                        state <= S_DATA;
                    end else begin
                        byte_idx <= byte_idx + 3'd1;
                    end
                end
                S_FETCH: begin
                    if (idx_rise || disk_error_i) begin
                        state <= S_DONE;
                    end else if (dma_ack_i) begin
                        if (last_byte) begin
                            state <= S_DATA;
                        end else begin
                            byte_idx <= byte_idx + 3'd1;
                            state <= S_HDR;
                        end
                    end
                end
                S_SEARCH: begin
                    if (idx_rise) begin
                        seen_idx <= 1'b1;
                    end
                    if (disk_error_i || (idx_rise && seen_idx)) begin
                        state <= S_DONE;
                    end else if (hdr_match_i) begin
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (disk_error_i) begin
                        state <= S_DONE;
                    end else if (idx_rise && cur_class == CL_FORMAT) begin
                        state <= S_DONE;
                    end else if (sector_done_i) begin
                        byte_idx <= 3'd0;
                        if (cur_class == CL_SINGLE ||
                            sector_operations_count <= 8'h01) begin
                            state <= S_DONE;
                        end else if (cur_class == CL_FORMAT) begin
                            state <= S_HDR;
                        end else if (cur_class == CL_MULTI) begin
                            seen_idx <= 1'b0;
                            state <= S_SEARCH;
                        end
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Counters: sector up, operations down after each sector
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sector_number_counter <= 8'h00;
            sector_operations_count <= 8'h00;
        end else if (sector_end && !disk_error_i) begin
            sector_number_counter <= sector_number_counter + 8'h01;
            if (sector_operations_count != 8'h00) begin
                sector_operations_count <= sector_operations_count - 8'h01;
            end
        end else if (wr_en && state == S_IDLE) begin
            if (paddr_i == OFF_SECTOR_CNT) begin
                sector_number_counter <= pwdata_i[7:0];
            end
            if (paddr_i == OFF_SECTOR_OPS) begin
                sector_operations_count <= pwdata_i[7:0];
            end
        end
    end

    // Table pointer: pad byte skipped after an odd-sized set
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            dma_addr_o <= 16'h0000;
        end else if (state == S_FETCH && dma_ack_i) begin
            dma_addr_o <= (last_byte && hdr_count[0]) ?
                dma_addr_o + 16'h0002 : dma_addr_o + 16'h0001;
        end else if (wr_en && paddr_i == OFF_DMA_ADDR && state == S_IDLE) begin
            dma_addr_o <= pwdata_i[15:0];
        end
    end

    // Interlock: confirm flag and pending late error
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            confirmed <= 1'b0;
            late_pend <= 1'b0;
        end else begin
            if (state == S_HDR && last_byte && !in_table ||
                state == S_FETCH && dma_ack_i && last_byte) begin
                confirmed <= 1'b0;
            end else if (confirm_wr) begin
                confirmed <= 1'b1;
            end
            if (sector_end && op_cmd[OC_INTERLOCK] && !confirmed &&
                !confirm_wr) begin
                late_pend <= 1'b1;
            end else if (cmd_wr && state == S_IDLE) begin
                late_pend <= 1'b0;
            end
        end
    end

    // Status and error: write one to clear, hardware set wins
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            status <= 4'h0;
            error <= 4'h0;
        end else begin
            status[ST_BUSY] <= (state != S_IDLE);
            if (state == S_DONE) begin
                status[ST_DONE] <= 1'b1;
            end else if (wr_en && paddr_i == OFF_STATUS &&
                pwdata_i[ST_DONE]) begin
                status[ST_DONE] <= 1'b0;
            end
            if (op_cmd[OC_INTERLOCK] && cur_class == CL_FORMAT &&
                (state == S_HDR && last_byte && !in_table ||
                 state == S_FETCH && dma_ack_i && last_byte)) begin
                status[ST_HDR_CPL] <= 1'b1;
            end else if (wr_en && paddr_i == OFF_STATUS &&
                pwdata_i[ST_HDR_CPL]) begin
                status[ST_HDR_CPL] <= 1'b0;
            end
            status[ST_ERROR] <= |error;
            // Clears first, so a set in the same cycle wins
            if (start_cmd && wr_class == CL_REENABLE) begin
                error <= 4'h0;
            end else if (wr_en && paddr_i == OFF_ERROR) begin
                for (int i = 0; i < 4; i++) begin
                    if (pwdata_i[i] && !(error[i] == 1'b0)) begin
                        error[i] <= 1'b0;
                    end
                end
            end
            if (cmd_wr && state == S_IDLE && late_pend) begin
                error[ER_LATE] <= 1'b1;
            end
            if (state == S_IDLE && start_cmd && wr_class == CL_BAD) begin
                error[ER_OPCODE] <= 1'b1;
            end
            if (state != S_IDLE && state != S_DONE && disk_error_i) begin
                error[ER_DISK] <= 1'b1;
            end
            if (state == S_SEARCH && idx_rise && seen_idx) begin
                error[ER_NOT_FOUND] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Disk, DMA and interrupt outputs
    // ------------------------------------------------------------------
    // No header byte once the format is cut by index or error
    assign hif.load = !idx_rise && !disk_error_i &&
        ((state == S_HDR && !in_table) || (state == S_FETCH && dma_ack_i));
    assign hif.idx = byte_idx;
    assign hif.table_mode = in_table;
    assign hif.dma_byte = dma_data_i;
    assign hif.sector_cnt = sector_number_counter;
    assign hif.pattern = hdr_pat;
    assign hif.subst = sector_counter_substitute;
    assign hdr_byte_o = hif.byte_out;
    assign hdr_strobe_o = hif.strobe;
    assign dma_req_o = (state == S_FETCH);
    assign fmt_active_o = (cur_class == CL_FORMAT) &&
        (state == S_HDR || state == S_FETCH || state == S_DATA);
    assign bus_req_o = (state == S_DATA) && (cur_class != CL_FORMAT);
    assign irq_o = op_cmd[OC_GLOBAL_IRQ] &&
        (status[ST_DONE] || (|error) ||
         (op_cmd[OC_HDR_IRQ] && status[ST_HDR_CPL]));
endmodule : dfs_top

// ---- tb/dfs_top_sva.sv ----
// Checker: port-level timing properties of the sequencer top.
// Assumes it is bound into every dfs_top instance.
`timescale 1ns/1ps
module dfs_top_sva (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic index_i,
    input wire logic hdr_strobe_o,
    input wire logic fmt_active_o,
    input wire logic bus_req_o,
    input wire logic dma_req_o,
    input wire logic dma_ack_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    chk_fetch_held: assert property (
        dma_req_o && !dma_ack_i |=> dma_req_o) else $error("fetch dropped");
    chk_fetch_in_fmt: assert property (
        dma_req_o |-> fmt_active_o) else $error("fetch outside format");
    chk_strobe_in_fmt: assert property (
        hdr_strobe_o |-> fmt_active_o) else $error("header outside format");
    chk_bus_not_fmt: assert property (
        fmt_active_o |-> !bus_req_o) else $error("bus request in format");
    chk_fmt_at_index: assert property (
        $rose(fmt_active_o) |-> $past(index_i, 3)) else $error("no index");
    chk_unmapped_err: assert property (
        psel_i && penable_i && paddr_i == 8'h40 |-> pslverr_o)
        else $error("unmapped not refused");
    chk_cmd_mapped: assert property (
        psel_i && penable_i && paddr_i == 8'h00 |-> !pslverr_o)
        else $error("command refused");
    chk_zero_wait: assert property (
        psel_i && !penable_i |=> pready_o) else $error("access stalled");
endmodule : dfs_top_sva
bind dfs_top dfs_top_sva u_sva (.*);

// ---- tb/dfs_mem_model.sv ----
// Memory model serving header table bytes to the fetch channel.
// Assumes each request is held until its acknowledge.
`timescale 1ns/1ps
module dfs_mem_model (
    input wire logic clk_sys_i,
    input wire logic req_i,
    input wire logic [15:0] addr_i,
    output logic [7:0] data_o,
    output logic ack_o
);
    int wait_cnt = 0;
    initial data_o = 8'h00;
    initial ack_o = 1'b0;
    always @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        data_o <= ~data_o; // Released bus shows no stale byte
        // Odd addresses answer late to stall the sequencer
        if (req_i && !ack_o && wait_cnt < 3 * addr_i[0]) begin
            wait_cnt <= wait_cnt + 1;
        end else if (req_i && !ack_o) begin
            wait_cnt <= 0;
            ack_o <= 1'b1;
            data_o <= addr_i[7:0] ^ 8'ha5;
        end
    end
endmodule : dfs_mem_model

// ---- tb/dfs_top_bench.sv ----
// Bench: drives the sequencer over APB and the disk strobes.
// Assumes the memory model answers the table fetches.
`timescale 1ns/1ps
module dfs_top_bench;
import dfs_pkg::*;
logic clk_sys_i = 0, sys_rst_i = 1, psel = 0, pen = 0, pwr = 0;
logic idx = 0, hm = 0, sd = 0, de = 0, re, hst, fa, br, dr, dak, irq, rdy;
logic [7:0] pa = 0, hb, dd;
logic [31:0] pwd = 0, prd, rv, rer;
logic [15:0] da;
logic [7:0] q[$];
logic [7:0] ops[17] = '{8'hd2, 8'h72, 8'hd6, 8'hd4, 8'hc4, 8'h74, 8'hf4,
    8'h92, 8'h96, 8'h84, 8'hac, 8'ha4, 8'h52, 8'h56, 8'h62, 8'h01, 8'h00};
int fail_count = 0, samples_checked = 0;
always #50 clk_sys_i = ~clk_sys_i;
always @(posedge clk_sys_i) if (hst === 1'b1) q.push_back(hb);
dfs_top u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(re), .index_i(idx),
    .hdr_match_i(hm), .sector_done_i(sd), .disk_error_i(de),
    .hdr_byte_o(hb), .hdr_strobe_o(hst), .fmt_active_o(fa),
    .bus_req_o(br), .dma_req_o(dr), .dma_addr_o(da), .dma_data_i(dd),
    .dma_ack_i(dak), .irq_o(irq));
dfs_mem_model u_mem (.clk_sys_i(clk_sys_i), .req_i(dr), .addr_i(da),
    .data_o(dd), .ack_o(dak));
task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask : conclude
task automatic ck(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
        fail_count++;
        $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
endtask : ck
task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i) {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk_sys_i) pen <= 1'b1;
    do @(posedge clk_sys_i); while (rdy !== 1'b1);
    rv = prd;
    rer = re;
    {psel, pen} <= 2'b00;
endtask : ap
task automatic pl(input int k);
    @(posedge clk_sys_i) {hm, sd, de} <= 3'b100 >> k;
    @(posedge clk_sys_i) {hm, sd, de} <= 3'b000;
    @(negedge clk_sys_i);
endtask : pl
task automatic fmt(input int n, input int m, input bit c);
    q.delete();
    ap(1, OFF_DRIVE_CMD, 32'(format_track_cmd));
    @(posedge clk_sys_i) idx <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    idx <= 1'b0;
    for (int s = 1; s <= n; s++) begin
        for (int i = 0; i < 300 && q.size() < s * m; i++) @(posedge clk_sys_i);
        if (c) ap(1, OFF_INTERLOCK, 1);
        pl(1);
    end
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
endtask : fmt
initial begin
    #3000000 fail_count++;
    conclude();
end
initial begin
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    ap(0, 8'h40, 0); ck(rer, 1);
    ap(1, OFF_HDR_COUNT, 2); ap(1, OFF_HDR_PAT_LO, 32'hc3);
    ap(1, OFF_HDR_SUBST, 2); ap(1, OFF_SECTOR_CNT, 5);
    ap(1, OFF_SECTOR_OPS, 2);
    ap(1, OFF_OP_CMD, 1); ap(1, OFF_DISK_FMT, 0);
    ck(fa, 0);
    fmt(2, 2, 0);
    ck({q[0], q[1], q[2], q[3]}, 32'hc305c306);
    ck(irq, 1);
    ap(0, OFF_SECTOR_CNT, 0); ck(rv, 7);
    ap(0, OFF_STATUS, 0); ck(rv, 2);
    ap(1, OFF_STATUS, 6); ap(1, OFF_HDR_COUNT, 3); ap(1, OFF_SECTOR_OPS, 2);
    ap(1, OFF_DMA_ADDR, 32'h100); ap(1, OFF_DISK_FMT, 1);
    fmt(2, 3, 0);
    ck(q.size(), 6);
    foreach (q[i]) ck(q[i], (i + i / 3) ^ 8'ha5);
    ap(1, OFF_STATUS, 6); ap(1, OFF_DISK_FMT, 0);
    ap(1, OFF_SECTOR_OPS, 1); ap(1, OFF_OP_CMD, 7);
    fmt(1, 3, 0);
    ap(0, OFF_STATUS, 0); ck(rv, 6);
    ap(1, OFF_DRIVE_CMD, 0); ap(0, OFF_ERROR, 0); ck(rv[0], 1);
    ap(1, OFF_ERROR, 15); ap(1, OFF_STATUS, 15); ap(1, OFF_SECTOR_OPS, 1);
    fmt(1, 3, 1); ap(1, OFF_DRIVE_CMD, 0);
    ap(0, OFF_ERROR, 0); ck(rv, 0);
    ap(1, OFF_STATUS, 15);
    ap(1, OFF_DRIVE_CMD, 32'(read_one_sector_cmd));
    ap(1, OFF_OP_CMD, 1);
    pl(0); ck(br, 1);
    pl(1); ck(br, 0);
    repeat (2) @(negedge clk_sys_i);
    ck(irq, 1);
    ap(1, OFF_DRIVE_CMD, 8'h54); ap(0, OFF_ERROR, 0); ck(rv[1], 1);
    foreach (ops[i]) begin
        ap(1, OFF_DRIVE_CMD, ops[i]); ap(0, OFF_STATUS, 0);
        ck(rv[0], i < 15);
        pl(2); ap(1, OFF_ERROR, 15); ap(1, OFF_STATUS, 15);
    end
    conclude();
end
endmodule : dfs_top_bench
